// ==== shared/sms_pkg.sv ====
// Purpose: shared constants and types for the serial shifter
// Assumes: 50 MHz system clock, byte transfers, mode 0 framing
// Notes: no software registers; control arrives on ports
package sms_pkg;
	localparam int unsigned CLK_MHZ = 50;
	localparam int unsigned SCK_HALF_NS = 160;
	localparam int unsigned SCK_HALF_CYC = (SCK_HALF_NS * CLK_MHZ) / 1000;
	localparam logic [4:0] HALF_LAST = 5'(SCK_HALF_CYC - 1);
	localparam logic [3:0] BITS_PER_BYTE = 4'h8;
	localparam logic [7:0] BYTE_ZERO = 8'h00;
	localparam int unsigned SYNC_W = 3;

	typedef enum logic [1:0] {
		SMS_IDLE = 2'b00,
		SMS_LOW = 2'b01,
		SMS_HIGH = 2'b11
	} sms_state_t;

	typedef struct packed {
		logic master_mode;
		logic transfer_irq_enable;
	} sms_ctrl_t;

	typedef struct packed {
		logic sck;
		logic mosi;
		logic ss_n;
	} sms_pins_in_t;
endpackage

// ==== verilog/sms_sync.sv ====
// Purpose: two-flop synchroniser for a group of pin inputs
// Assumes: inputs asynchronous to CLOCK
// Notes: first stage read only by the second
`timescale 1ns/10ps
module sms_sync #(
	parameter int unsigned W = 1
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// data
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] meta_reg;

	// no reset on purpose: stages follow the pins during reset, so release
	// never shows a false level (select would read low and look active)
	always_ff @(posedge clk) begin
		meta_reg <= d;
		q <= meta_reg;
	end
endmodule

// ==== verilog/sms_edge.sv ====
// Purpose: rise and fall detector on a synchronised level
// Assumes: input already synchronised
// Notes: pulses last one cycle
`timescale 1ns/10ps
module sms_edge (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// level in, pulses out
	input wire logic level,
	output logic rise,
	output logic fall
);
	logic last_reg;

	// tracks the level through reset too, so release brings no false edge
	always_ff @(posedge clk) begin
		last_reg <= level;
	end

	assign rise = level & ~last_reg;
	assign fall = ~level & last_reg;
endmodule

// ==== verilog/sms_shifter.sv ====
// Purpose: byte serial shifter, master or slave, mode 0 framing
// Assumes: sck idles low; sample on rise, shift on fall
// Notes: master select line is left to software
// Function
// - software lowers select before a master transfer; slave shifts only while select low
// - data goes out on mosi as master, miso as slave, clocked by master sck
// - in master mode the device never drives the select line
// - master data write starts sck generator, shifting exactly eight bits
// - master clock stops by itself after one byte and flag is set
// - flag setting raises interrupt when transfer interrupt enable is set
// - last received byte stays readable in receive buffer
// - slave with select high stays idle with miso released
// - slave data written while select high waits until select goes low
// - slave sets the done flag after a full byte shifted in
// - slave accepts new outgoing byte without disturbing received byte
// - transmit single buffered: writes refused while shifting
// - receive double buffered: unread byte overwritten by next byte
`timescale 1ns/10ps
module sms_shifter
	import sms_pkg::*;
(
	// clock and reset
	input wire logic CLOCK,
	input wire logic RST_N,
	// control
	input wire sms_pkg::sms_ctrl_t CTRL,
	// software data port
	input wire logic WR_STB,
	input wire logic [7:0] WR_DATA,
	input wire logic RD_STB,
	input wire logic FLAG_CLR,
	output logic [7:0] RX_DATA,
	output logic TRANSFER_DONE_FLAG,
	output logic IRQ,
	output logic BUSY,
	output logic WR_REFUSED,
	// serial pins
	input wire logic SCK_IN,
	input wire logic MOSI_IN,
	input wire logic MISO_IN,
	input wire logic SS_N_IN,
	output logic SCK_OUT,
	output logic SCK_OE,
	output logic MOSI_OUT,
	output logic MOSI_OE,
	output logic MISO_OUT,
	output logic MISO_OE
);
	import sms_pkg::*;

	sms_pins_in_t pins_raw;
	sms_pins_in_t pins_s;
	logic miso_s;
	logic sck_rise;
	logic sck_fall;
	logic ss_rise;

	sms_state_t state_reg, state_next;
	logic [4:0] half_reg;
	logic [3:0] bit_reg;
	logic [7:0] shift_reg;
	logic sample_reg;
	logic byte_done;
	logic slave_active;
	logic wr_ok;

	assign pins_raw = '{sck: SCK_IN, mosi: MOSI_IN, ss_n: SS_N_IN};

	// slave-side pins and miso all cross from outside
	sms_sync #(.W(SYNC_W)) u_sync_pins (
		.clk(CLOCK),
		.rst_n(RST_N),
		.d(pins_raw),
		.q(pins_s)
	);

	sms_sync #(.W(1)) u_sync_miso (
		.clk(CLOCK),
		.rst_n(RST_N),
		.d(MISO_IN),
		.q(miso_s)
	);

	sms_edge u_edge_sck (
		.clk(CLOCK),
		.rst_n(RST_N),
		.level(pins_s.sck),
		.rise(sck_rise),
		.fall(sck_fall)
	);

	sms_edge u_edge_ss (
		.clk(CLOCK),
		.rst_n(RST_N),
		.level(pins_s.ss_n),
		.rise(ss_rise),
		.fall()
	);

	// slave works only while select is low
	assign slave_active = !CTRL.master_mode && !pins_s.ss_n;

	// writes accepted only when no byte is in flight
	assign wr_ok = (state_reg == SMS_IDLE) && !(slave_active && bit_reg != 4'h0);

	// state machine: master counts half periods, slave follows sck edges
	always_comb begin
		state_next = state_reg;
		byte_done = 1'b0;
		case (state_reg)
			SMS_IDLE: begin
				if (CTRL.master_mode && WR_STB) begin
					state_next = SMS_LOW;
				end
			end
			SMS_LOW: begin
				if (half_reg == HALF_LAST) begin
					state_next = SMS_HIGH;
				end
			end
			SMS_HIGH: begin
				if (half_reg == HALF_LAST) begin
					if (bit_reg == BITS_PER_BYTE - 4'h1) begin
						state_next = SMS_IDLE;
						byte_done = 1'b1;
					end else begin
						state_next = SMS_LOW;
					end
				end
			end
			default: begin
				state_next = SMS_IDLE;
			end
		endcase
		if (!CTRL.master_mode) begin
			state_next = SMS_IDLE;
			byte_done = slave_active && sck_rise && bit_reg == BITS_PER_BYTE - 4'h1;
		end
	end

	always_ff @(posedge CLOCK) begin
		if (!RST_N) begin
			state_reg <= SMS_IDLE;
		end else begin
			state_reg <= state_next;
		end
	end

	// half period counter for the master clock generator
	always_ff @(posedge CLOCK) begin
		if (!RST_N) begin
			half_reg <= 5'h00;
		end else if (state_reg == SMS_IDLE || half_reg == HALF_LAST) begin
			half_reg <= 5'h00;
		end else begin
			half_reg <= half_reg + 5'h01;
		end
	end

	// bit counter; select high resets slave framing
	always_ff @(posedge CLOCK) begin
		if (!RST_N) begin
			bit_reg <= 4'h0;
		end else if (CTRL.master_mode) begin
			if (state_reg == SMS_IDLE) begin
				bit_reg <= 4'h0;
			end else if (state_reg == SMS_HIGH && half_reg == HALF_LAST) begin
				bit_reg <= bit_reg + 4'h1;
			end
		end else if (pins_s.ss_n || ss_rise) begin
			bit_reg <= 4'h0;
		end else if (sck_rise) begin
			bit_reg <= byte_done ? 4'h0 : bit_reg + 4'h1;
		end
	end

	// shift register: sample on sck rise, shift on sck fall, msb first
	always_ff @(posedge CLOCK) begin
		if (!RST_N) begin
			shift_reg <= BYTE_ZERO;
			sample_reg <= 1'b0;
		end else if (WR_STB && wr_ok) begin
			shift_reg <= WR_DATA;
		end else if (CTRL.master_mode) begin
			if (state_reg == SMS_LOW && half_reg == HALF_LAST) begin
				sample_reg <= miso_s;
			end else if (state_reg == SMS_HIGH && half_reg == HALF_LAST) begin
				shift_reg <= {shift_reg[6:0], sample_reg};
			end
		end else if (slave_active) begin
			if (sck_rise) begin
				sample_reg <= pins_s.mosi;
			end else if (sck_fall) begin
				shift_reg <= {shift_reg[6:0], sample_reg};
			end
		end
	end

	// receive buffer, flag and interrupt; byte_done set wins over clear
	always_ff @(posedge CLOCK) begin
		if (!RST_N) begin
			RX_DATA <= BYTE_ZERO;
			TRANSFER_DONE_FLAG <= 1'b0;
			IRQ <= 1'b0;
		end else begin
			if (byte_done) begin
				// slave byte completes on last rise, before the final shift
				RX_DATA <= CTRL.master_mode ? {shift_reg[6:0], sample_reg} :
					{shift_reg[6:0], pins_s.mosi};
				TRANSFER_DONE_FLAG <= 1'b1;
			end else if (FLAG_CLR || RD_STB) begin
				TRANSFER_DONE_FLAG <= 1'b0;
			end
			IRQ <= (byte_done || (TRANSFER_DONE_FLAG && !(FLAG_CLR || RD_STB)))
				&& CTRL.transfer_irq_enable;
		end
	end

	// pin drivers; select is never driven here
	always_ff @(posedge CLOCK) begin
		if (!RST_N) begin
			SCK_OUT <= 1'b0;
			SCK_OE <= 1'b0;
			MOSI_OUT <= 1'b0;
			MOSI_OE <= 1'b0;
			MISO_OUT <= 1'b0;
			MISO_OE <= 1'b0;
			BUSY <= 1'b0;
			WR_REFUSED <= 1'b0;
		end else begin
			SCK_OUT <= CTRL.master_mode && state_next == SMS_HIGH;
			SCK_OE <= CTRL.master_mode;
			MOSI_OUT <= state_next == SMS_LOW && state_reg == SMS_IDLE ? WR_DATA[7] :
				(state_reg == SMS_HIGH && half_reg == HALF_LAST ? shift_reg[6] : shift_reg[7]);
			MOSI_OE <= CTRL.master_mode;
			MISO_OUT <= (WR_STB && wr_ok) ? WR_DATA[7] :
				(sck_fall ? shift_reg[6] : shift_reg[7]);
			MISO_OE <= !CTRL.master_mode && !pins_s.ss_n;
			BUSY <= state_next != SMS_IDLE || (slave_active && bit_reg != 4'h0);
			WR_REFUSED <= WR_STB && !wr_ok;
		end
	end
endmodule

// ==== sim/sms_partner.sv ====
// Purpose: far spi slave for master mode
// Assumes: mode 0, msb first
// Notes: released miso shows the inverse bit
`timescale 1ns/10ps
module sms_partner (
	// serial link from the master
	input wire logic sck,
	input wire logic ss_n,
	input wire logic mosi,
	// byte to return
	input wire logic [7:0] tx,
	// reply and capture
	output logic miso,
	output logic [7:0] rx
);
	logic [7:0] sh;

	always @(negedge ss_n) sh = tx;
	always @(posedge sck) if (!ss_n) rx = {rx[6:0], mosi};
	always @(negedge sck) if (!ss_n) sh = {sh[6:0], 1'b0};
	// released line shows the inverse so a late sample is caught
	assign miso = ss_n ? ~sh[7] : sh[7];
endmodule

// ==== sim/sms_sva.sv ====
// Purpose: port checks for the shifter
// Assumes: bound to sms_shifter
// Notes: slave pin timing left to bench
`timescale 1ns/10ps
module sms_sva
	import sms_pkg::*;
(
	// clock and reset
	input wire logic CLOCK,
	input wire logic RST_N,
	// control and software port
	input wire sms_pkg::sms_ctrl_t CTRL,
	input wire logic WR_STB,
	input wire logic BUSY,
	input wire logic WR_REFUSED,
	input wire logic TRANSFER_DONE_FLAG,
	input wire logic IRQ,
	input wire logic [7:0] RX_DATA,
	// pins
	input wire logic SS_N_IN,
	input wire logic SCK_OUT,
	input wire logic SCK_OE,
	input wire logic MOSI_OE,
	input wire logic MISO_OE
);
	default clocking cb @(posedge CLOCK); endclocking
	default disable iff (!RST_N);
	logic [3:0] rise_cnt;
	always_ff @(posedge CLOCK) begin
		if (!RST_N || $rose(BUSY)) rise_cnt <= 4'h0;
		else if ($rose(SCK_OUT)) rise_cnt <= rise_cnt + 4'h1;
	end
	sequence m_idle; CTRL.master_mode && !BUSY; endsequence
	sequence m_start; CTRL.master_mode && $rose(BUSY); endsequence
	sequence m_end; CTRL.master_mode && $fell(BUSY); endsequence
	AST_BYTE_TIME: assert property (m_start |-> ##[124:132] TRANSFER_DONE_FLAG)
		else $error("master byte late");
	AST_EIGHT: assert property (m_end |-> rise_cnt == 4'h8)
		else $error("wrong bit count");
	AST_STOP: assert property (m_idle ##1 m_idle |-> !SCK_OUT)
		else $error("clock runs while idle");
	AST_FLAG: assert property (m_end |-> ##[0:1] TRANSFER_DONE_FLAG)
		else $error("flag missing");
	AST_IRQ: assert property ((TRANSFER_DONE_FLAG && CTRL.transfer_irq_enable)[*2] |-> IRQ)
		else $error("irq missing");
	AST_NO_IRQ: assert property ((!(TRANSFER_DONE_FLAG && CTRL.transfer_irq_enable))[*2] |-> !IRQ)
		else $error("stray irq");
	AST_RX_LOAD: assert property ($changed(RX_DATA) |-> TRANSFER_DONE_FLAG)
		else $error("rx moved without flag");
	AST_REFUSE: assert property (CTRL.master_mode && WR_STB && BUSY |=> WR_REFUSED)
		else $error("busy write not refused");
	AST_QUIET: assert property ((!CTRL.master_mode && SS_N_IN)[*4] |-> !MISO_OE)
		else $error("miso driven unselected");
	AST_PINS: assert property (CTRL.master_mode[*2] |-> MOSI_OE && SCK_OE && !MISO_OE)
		else $error("master pin enables wrong");
endmodule

// ==== sim/sms_shifter_tb.sv ====
// Purpose: self-checking bench for the shifter
// Assumes: bench drives on falling clock
// Notes: flag rise pops the expected rx byte
`timescale 1ns/10ps
module sms_shifter_tb;
	import sms_pkg::*;
	logic clk = 0, rst_n = 0, wr = 0, rd = 0, clr = 0, sck = 0, mosi = 0, ss_n = 1, p_ss = 1;
	sms_ctrl_t ctrl = '0;
	logic [7:0] wd = 8'h00, ptx = 8'h00, last_m = 8'h00;
	wire [7:0] rxd, prx;
	wire flag, irq, busy, refd, sck_o, sck_oe, mo, mo_oe, mi, mi_oe, pmiso;
	int error_cnt = 0, tests_run = 0, cyc = 0;
	logic [7:0] exp_q[$];
	initial forever #10 clk = ~clk;
	sms_shifter u_dut(.CLOCK(clk), .RST_N(rst_n), .CTRL(ctrl), .WR_STB(wr), .WR_DATA(wd), .RD_STB(rd),
		.FLAG_CLR(clr), .RX_DATA(rxd), .TRANSFER_DONE_FLAG(flag), .IRQ(irq), .BUSY(busy),
		.WR_REFUSED(refd), .SCK_IN(sck), .MOSI_IN(mosi), .MISO_IN(pmiso), .SS_N_IN(ss_n),
		.SCK_OUT(sck_o), .SCK_OE(sck_oe), .MOSI_OUT(mo), .MOSI_OE(mo_oe), .MISO_OUT(mi), .MISO_OE(mi_oe));
	sms_partner u_far(.sck(sck_o), .ss_n(p_ss), .mosi(mo), .tx(ptx), .miso(pmiso), .rx(prx));
	task automatic chk(input logic [7:0] got, exp);
		tests_run++;
		if (got !== exp) begin
			error_cnt++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic test_done;
		$display("checks %0d errors %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	task automatic tick(input int n);
		repeat (n) @(negedge clk);
	endtask
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc > 5000) begin
			error_cnt++;
			test_done();
		end
	end
	// an unexpected flag rise finds the queue empty and counts as a mismatch
	always @(posedge flag) begin
		#1;
		if (exp_q.size() > 0) chk(rxd, exp_q.pop_front());
		else chk({7'h0, flag}, 8'h00);
	end
	task automatic mbyte(input logic [7:0] d, p, input logic by_rd);
		int n;
		n = 0;
		ptx = p;
		wd = d;
		exp_q.push_back(p);
		p_ss = 0;
		tick(1);
		wr = 1;
		tick(1);
		wr = 0;
		chk({7'h0, busy}, 8'h01);
		tick(1);
		wd = ~d;
		wr = 1;
		tick(1);
		wr = 0;
		chk({7'h0, refd}, 8'h01);
		while (flag !== 1'b1 && n < 300) begin
			tick(1);
			n++;
		end
		chk({7'h0, flag}, 8'h01);
		chk({7'h0, busy}, 8'h00);
		chk({7'h0, sck_o}, 8'h00);
		tick(2);
		chk(prx, d);
		chk({7'h0, irq}, {7'h0, ctrl.transfer_irq_enable});
		p_ss = 1;
		rd = by_rd;
		clr = !by_rd;
		tick(1);
		rd = 0;
		clr = 0;
		tick(1);
		chk({7'h0, flag}, 8'h00);
	endtask
	// sck half period of 4 clocks keeps margin over the sync delay
	task automatic sbyte(input logic [7:0] m, t);
		logic [7:0] got;
		wd = t;
		wr = 1;
		tick(1);
		wr = 0;
		if (flag === 1'b1) chk(rxd, last_m);
		else exp_q.push_back(m);
		repeat (2) begin
			sck = 1;
			tick(4);
			sck = 0;
			tick(4);
		end
		chk({7'h0, mi_oe}, 8'h00);
		ss_n = 0;
		tick(2);
		for (int i = 7; i >= 0; i--) begin
			mosi = m[i];
			if (i == 3) begin
				wd = ~t;
				wr = 1;
			end
			tick(2);
			if (i == 3) begin
				wr = 0;
				chk({7'h0, refd}, 8'h01);
			end
			if (i == 7) chk({7'h0, mi_oe}, 8'h01);
			got[i] = mi;
			sck = 1;
			tick(4);
			sck = 0;
			tick(2);
		end
		ss_n = 1;
		tick(4);
		chk(got, t);
		chk(rxd, m);
		chk({7'h0, irq}, 8'h01);
		last_m = m;
	endtask
	initial begin
		void'($urandom(84));
		tick(6);
		rst_n = 1;
		tick(3);
		ctrl.master_mode = 1;
		for (int i = 0; i < 4; i++) begin
			ctrl.transfer_irq_enable = i[0];
			mbyte(i == 0 ? 8'h00 : i == 1 ? 8'hff : 8'($urandom), 8'($urandom), i[1]);
		end
		ctrl = 2'b01;
		tick(2);
		sbyte(8'($urandom), 8'h00);
		sbyte(8'hff, 8'($urandom));
		rd = 1;
		tick(1);
		rd = 0;
		tick(1);
		sbyte(8'($urandom), 8'hff);
		test_done();
	end
endmodule
bind sms_shifter sms_sva u_sva(.CLOCK(CLOCK), .RST_N(RST_N), .WR_STB(WR_STB), .SS_N_IN(SS_N_IN),
	.BUSY(BUSY), .WR_REFUSED(WR_REFUSED), .TRANSFER_DONE_FLAG(TRANSFER_DONE_FLAG), .IRQ(IRQ),
	.CTRL(CTRL), .RX_DATA(RX_DATA), .SCK_OUT(SCK_OUT), .SCK_OE(SCK_OE), .MOSI_OE(MOSI_OE), .MISO_OE(MISO_OE));
